// ### src/sfp_ctrl.sv
// Serial flash command front end with write protect and reset control
//
// Behaviour
// - Serial out changes on falling shift clock
// - Pin protect blocks mapped sectors always
// - Sector protected by pin or command
// - Map writes refused while pin low
// - Blocked program or erase is discarded
// - Discarded command idles at deselect
// - Enable and lock accepted while pin low
// - Floating protect pin reads deasserted
// - Reset low aborts, state to idle
// - Held in reset while pin low
// - Resume when reset pin high
// - Internal power-on reset generated
// - Array addressed as sector, block, page
// - Program touches exactly one page
// - Erase chip, sector, block or page
// - Select edges frame each command
// - Input sampled on rising shift clock
// - Opcode then address, MSB first
`timescale 1ns/1ps
module sfp_ctrl #(
    parameter int SECTORS = sfp_pkg::SECTOR_COUNT,
    parameter int POR_LEN = sfp_pkg::POR_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    input wire logic device_select_n,
    input wire logic shift_clock,
    input wire logic serial_in_line,
    input wire logic write_protect_n,
    input wire logic write_protect_driven,
    input wire logic [7:0] opcode_op,
    input wire logic opcode_known,
    input wire logic read_bit,
    input wire logic [SECTORS-1:0] map_write_data,
    output logic [7:0] opcode_seen,
    output sfp_pkg::sfp_cmd_t array_cmd,
    output logic [SECTORS-1:0] protected_sector_map,
    output logic protection_enabled,
    output logic permanent_lock,
    output logic command_discarded,
    output logic serial_out_line,
    output logic serial_out_en
);

    ////////////////////////////////////////////////////////////////////
    // Reset: power-on stretch combined with the reset pin
    logic [4:0] por_count;
    logic [4:0] next_por_count;
    logic por_done;
    logic run;
    always_comb begin
        next_por_count = por_count;
        if (!por_done) begin
            next_por_count = por_count + 5'h01;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_count <= sfp_pkg::POR_COUNT_RESET;
        end else begin
            por_count <= next_por_count;
        end
    end
    assign por_done = (32'(por_count) >= POR_LEN);
    assign run = por_done && reset_pin_n;

    ////////////////////////////////////////////////////////////////////
    // Edge detection of pins
    logic sck_q;
    logic cs_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sck_q <= shift_clock;
            cs_q <= device_select_n;
        end
    end
    assign sck_rise = shift_clock && !sck_q;
    assign sck_fall = !shift_clock && sck_q;
    assign cs_fall = !device_select_n && cs_q;
    assign cs_rise = device_select_n && !cs_q;

    logic wp_active;
    assign wp_active = write_protect_driven && !write_protect_n;

    ////////////////////////////////////////////////////////////////////
    // Command shifter and state machine
    sfp_pkg::sfp_state_t state;
    sfp_pkg::sfp_state_t next_state;
    logic [sfp_pkg::FRAME_BITS-1:0] shreg;
    logic [sfp_pkg::FRAME_BITS-1:0] next_shreg;
    logic [5:0] bit_count;
    logic [5:0] next_bit_count;
    sfp_pkg::sfp_cmd_t next_array_cmd;
    logic [SECTORS-1:0] next_map;
    logic next_prot_en;
    logic next_lock;
    logic next_discarded;
    logic next_so;
    logic next_so_en;
    sfp_pkg::sfp_op_t dec_op;
    logic [10:0] dec_page;
    logic [2:0] dec_sector;
    logic sector_hit;
    logic blocked;

    assign opcode_seen = shreg[sfp_pkg::OPCODE_BITS-1:0];
    assign dec_op = sfp_pkg::sfp_op_t'(opcode_op[3:0]);
    // Page address and sector derived
    assign dec_page = shreg[sfp_pkg::PAGE_ADDR_LSB +: sfp_pkg::PAGE_ADDR_BITS];
    assign dec_sector = dec_page[10:8];
    assign sector_hit = protected_sector_map[dec_sector] && (wp_active || protection_enabled);

    always_comb begin
        blocked = 1'b0;
        unique case (dec_op)
            sfp_pkg::SFP_OP_PROGRAM, sfp_pkg::SFP_OP_ERASE_PAGE,
            sfp_pkg::SFP_OP_ERASE_BLOCK, sfp_pkg::SFP_OP_ERASE_SECTOR: begin
                blocked = sector_hit || permanent_lock;
            end
            sfp_pkg::SFP_OP_ERASE_CHIP: begin
                blocked = ((|protected_sector_map) && (wp_active || protection_enabled))
                    || permanent_lock;
            end
            sfp_pkg::SFP_OP_MAP_WRITE, sfp_pkg::SFP_OP_PROT_DISABLE: begin
                blocked = wp_active || permanent_lock;
            end
            default: begin
                blocked = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_count = bit_count;
        next_array_cmd = '0;
        next_map = protected_sector_map;
        next_prot_en = protection_enabled;
        next_lock = permanent_lock;
        next_discarded = 1'b0;
        next_so = serial_out_line;
        next_so_en = serial_out_en;
        unique case (state)
            // Only a fresh select fall starts
            sfp_pkg::SFP_ST_IDLE: begin
                next_so_en = 1'b0;
                if (cs_fall) begin
                    next_state = sfp_pkg::SFP_ST_SHIFT;
                    next_bit_count = 6'h00;
                    next_shreg = '0;
                end
            end
            sfp_pkg::SFP_ST_SHIFT: begin
                if (cs_rise) begin
                    next_state = sfp_pkg::SFP_ST_IDLE;
                end else if (sck_rise) begin
                    next_shreg = {shreg[sfp_pkg::FRAME_BITS-2:0], serial_in_line};
                    next_bit_count = bit_count + 6'h01;
                end else if (32'(bit_count) == sfp_pkg::FRAME_BITS) begin
                    if (!opcode_known) begin
                        next_state = sfp_pkg::SFP_ST_DISCARD;
                    end else if (blocked) begin
                        next_discarded = 1'b1;
                        next_state = sfp_pkg::SFP_ST_DISCARD;
                    end else begin
                        next_state = sfp_pkg::SFP_ST_DISCARD;
                        unique case (dec_op)
                            sfp_pkg::SFP_OP_PROT_ENABLE: next_prot_en = 1'b1;
                            sfp_pkg::SFP_OP_PROT_DISABLE: next_prot_en = 1'b0;
                            sfp_pkg::SFP_OP_MAP_WRITE: next_map = map_write_data;
                            sfp_pkg::SFP_OP_LOCK: next_lock = 1'b1;
                            sfp_pkg::SFP_OP_READ: next_state = sfp_pkg::SFP_ST_OUT;
                            default: begin
                                next_array_cmd.valid = (dec_op != sfp_pkg::SFP_OP_NONE);
                                next_array_cmd.op = dec_op;
                                next_array_cmd.page = dec_page;
                                next_array_cmd.sector = dec_sector;
                            end
                        endcase
                    end
                end
            end
            sfp_pkg::SFP_ST_DISCARD: begin
                if (cs_rise) begin
                    next_state = sfp_pkg::SFP_ST_IDLE;
                end
            end
            sfp_pkg::SFP_ST_OUT: begin
                if (cs_rise) begin
                    next_state = sfp_pkg::SFP_ST_IDLE;
                    next_so_en = 1'b0;
                end else if (sck_fall) begin
                    next_so = read_bit;
                    next_so_en = 1'b1;
                end
            end
        endcase
    end

    // Abort to idle on reset pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= sfp_pkg::SFP_ST_IDLE;
            shreg <= '0;
            bit_count <= 6'h00;
            array_cmd <= '0;
            protected_sector_map <= SECTORS'(sfp_pkg::PROT_MAP_RESET);
            protection_enabled <= sfp_pkg::PROT_EN_RESET;
            permanent_lock <= 1'b0;
            command_discarded <= 1'b0;
            serial_out_line <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (!run) begin
            state <= sfp_pkg::SFP_ST_IDLE;
            bit_count <= 6'h00;
            array_cmd <= '0;
            command_discarded <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_count <= next_bit_count;
            array_cmd <= next_array_cmd;
            protected_sector_map <= next_map;
            protection_enabled <= next_prot_en;
            permanent_lock <= next_lock;
            command_discarded <= next_discarded;
            serial_out_line <= next_so;
            serial_out_en <= next_so_en;
        end
    end

endmodule // sfp_ctrl

// ### src/sfp_pkg.sv
// Package for the serial flash protect and reset control block
package sfp_pkg;
    // Serial framing
    localparam int OPCODE_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam int FRAME_BITS = OPCODE_BITS + ADDR_BITS;
    // Array geometry defaults
    localparam int SECTOR_COUNT = 8;
    localparam int PAGE_ADDR_BITS = 11;
    localparam int PAGE_ADDR_LSB = 8;
    localparam int BLOCK_PAGE_BITS = 3;
    localparam int SECTOR_PAGE_BITS = 8;
    // Power-on reset stretch in clock cycles
    localparam int POR_CYCLES = 16;
    localparam logic [4:0] POR_COUNT_RESET = 5'h00;
    localparam logic [7:0] PROT_MAP_RESET = 8'h00;
    localparam logic PROT_EN_RESET = 1'b0;

    typedef enum logic [3:0] {
        SFP_OP_NONE = 4'h0,
        SFP_OP_PROGRAM = 4'h1,
        SFP_OP_ERASE_PAGE = 4'h2,
        SFP_OP_ERASE_BLOCK = 4'h3,
        SFP_OP_ERASE_SECTOR = 4'h4,
        SFP_OP_ERASE_CHIP = 4'h5,
        SFP_OP_PROT_ENABLE = 4'h6,
        SFP_OP_PROT_DISABLE = 4'h7,
        SFP_OP_MAP_WRITE = 4'h8,
        SFP_OP_LOCK = 4'h9,
        SFP_OP_READ = 4'ha
    } sfp_op_t;

    // Decoded command handed to the array engine
    typedef struct packed {
        logic valid;
        sfp_op_t op;
        logic [10:0] page;
        logic [2:0] sector;
    } sfp_cmd_t;

    // Opcode table input from the command decoder
    typedef struct packed {
        sfp_op_t op;
        logic known;
    } sfp_decode_t;

    typedef enum logic [1:0] {
        SFP_ST_IDLE = 2'b00,
        SFP_ST_SHIFT = 2'b01,
        SFP_ST_DISCARD = 2'b10,
        SFP_ST_OUT = 2'b11
    } sfp_state_t;
endpackage

// ### dv/sfp_ctrl_chk.sv
// Assertion checker for the flash protect and reset block
`timescale 1ns/1ps
module sfp_ctrl_chk #(
    parameter int SECTORS = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    input wire logic device_select_n,
    input wire logic shift_clock,
    input wire logic write_protect_n,
    input wire logic write_protect_driven,
    input wire sfp_pkg::sfp_cmd_t array_cmd,
    input wire logic [SECTORS-1:0] protected_sector_map,
    input wire logic protection_enabled,
    input wire logic command_discarded,
    input wire logic serial_out_line,
    input wire logic serial_out_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    property p_so_fall;
        $changed(serial_out_line) && reset_pin_n && $past(reset_pin_n)
            |-> !$past(shift_clock) && ($past(shift_clock, 2) || $past(shift_clock, 3));
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("so moved off a fall");
    property p_drop;
        command_discarded |-> !array_cmd.valid ##1 !array_cmd.valid;
    endproperty
    a_drop: assert property (p_drop) else $error("dropped but issued");
    property p_rst;
        !reset_pin_n |=> !array_cmd.valid && !command_discarded && !serial_out_en;
    endproperty
    a_rst: assert property (p_rst) else $error("active in reset");
    property p_map_wp;
        $changed(protected_sector_map) |-> $past(write_protect_n) || !$past(write_protect_driven);
    endproperty
    a_map_wp: assert property (p_map_wp) else $error("map moved under protect");
    property p_idle;
        device_select_n [*3] |-> !array_cmd.valid && !command_discarded && !serial_out_en;
    endproperty
    a_idle: assert property (p_idle) else $error("active while idle");
    property p_page;
        array_cmd.valid |-> array_cmd.sector == array_cmd.page[10:8];
    endproperty
    a_page: assert property (p_page) else $error("sector not from page");
    property p_prot;
        array_cmd.valid && array_cmd.op inside {[4'h1:4'h4]}
            && (!write_protect_n && write_protect_driven || protection_enabled)
            |-> !protected_sector_map[array_cmd.sector];
    endproperty
    a_prot: assert property (p_prot) else $error("protected sector hit");
    property p_map_rst;
        !reset_pin_n [*3] |-> $stable(protected_sector_map);
    endproperty
    a_map_rst: assert property (p_map_rst) else $error("map moved in reset");
endmodule // sfp_ctrl_chk
bind sfp_ctrl sfp_ctrl_chk #(.SECTORS(SECTORS)) u_chk (.*);

// ### dv/sfp_host.sv
// Host controller model for the serial flash pins
`timescale 1ns/1ps
module sfp_host (
    input wire logic clk,
    input wire logic serial_out_line,
    output logic read_bit = 1'b0,
    output logic device_select_n = 1'b1,
    output logic shift_clock = 1'b0,
    output logic serial_in_line = 1'b0
);
    task automatic send(input logic [31:0] data);
        device_select_n = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            serial_in_line = data[i];
            repeat (2) @(negedge clk);
            shift_clock = 1'b1;
            repeat (2) @(negedge clk);
            shift_clock = 1'b0;
        end
        repeat (4) @(negedge clk);
        device_select_n = 1'b1;
        serial_in_line = ~serial_in_line;
        repeat (3) @(negedge clk);
    endtask
    // Read frame, data taken before each rise
    task automatic read(input logic [31:0] data, input logic [7:0] pat, output logic [7:0] got);
        read_bit = pat[7];
        device_select_n = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            serial_in_line = data[i];
            repeat (2) @(negedge clk);
            shift_clock = 1'b1;
            repeat (2) @(negedge clk);
            shift_clock = 1'b0;
        end
        for (int j = 7; j >= 0; j--) begin
            repeat (2) @(negedge clk);
            got[j] = serial_out_line;
            if (j > 0) begin
                read_bit = pat[j-1];
            end
            shift_clock = 1'b1;
            repeat (2) @(negedge clk);
            shift_clock = 1'b0;
        end
        repeat (4) @(negedge clk);
        device_select_n = 1'b1;
        serial_in_line = ~serial_in_line;
        repeat (3) @(negedge clk);
    endtask
endmodule // sfp_host

// ### dv/tb_top.sv
// Self-checking testbench for the flash protect and reset block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic reset_pin_n = 1'b1, write_protect_n = 1'b1, write_protect_driven = 1'b1;
    logic read_bit;
    logic [7:0] opcode_seen;
    logic [7:0] opcode_op = 8'h00, map_write_data = 8'h00, protected_sector_map;
    logic device_select_n, shift_clock, serial_in_line, serial_out_line, serial_out_en;
    logic protection_enabled, permanent_lock, command_discarded;
    sfp_pkg::sfp_cmd_t array_cmd, last_cmd;
    int err_total = 0, n_tests = 0, n_cmd = 0, n_drop = 0;
    initial forever #20 clk = ~clk;
    sfp_ctrl #(.SECTORS(8), .POR_LEN(4)) DUT (.*, .opcode_known(1'b1), .opcode_seen(opcode_seen));
    sfp_host host (.clk, .serial_out_line, .read_bit, .device_select_n, .shift_clock,
        .serial_in_line);
    always @(posedge clk) begin
        n_cmd += (array_cmd.valid === 1'b1);
        n_drop += (command_discarded === 1'b1);
        if (array_cmd.valid === 1'b1)
            last_cmd = array_cmd;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input logic [3:0] op, input logic [2:0] sec, input logic drop, arr);
        int c = n_cmd;
        int d = n_drop;
        opcode_op = {4'h0, op};
        host.send({4'h0, op, 5'h00, sec, 16'h5a00});
        check(32'(n_drop - d + 16 * arr * (n_cmd - c)), {27'h0, arr & ~drop, 3'h0, drop}, "n");
        if (arr && !drop)
            check(32'(last_cmd), 32'({1'b1, op, sec, 8'h5a, sec}), "cmd");
    endtask
    task automatic t_erase();
        for (int k = 2; k <= 5; k++) begin
            run(4'(k), 3'h5, 1'b0, 1'b1);
        end
    endtask
    task automatic t_por();
        int c = n_cmd;
        opcode_op = 8'h01;
        host.send(32'h0102_5a00);
        check(32'(n_cmd - c), 32'h0, "por frame");
    endtask
    task automatic t_read();
        logic [7:0] got;
        int c = n_cmd;
        opcode_op = 8'h0a;
        host.read(32'h0a01_5a3c, 8'ha5, got);
        check(32'(got), 32'ha5, "read data");
        check(32'(opcode_seen), 32'h3c, "last byte");
        check(32'(n_cmd - c), 32'h0, "read cmd");
        check(32'(serial_out_en), 32'h0, "read released");
    endtask
    task automatic t_reset();
        int c = n_cmd;
        int d = n_drop;
        reset_pin_n = 1'b0;
        opcode_op = 8'h01;
        fork
            host.send(32'h0103_5a00);
            begin
                repeat (40) @(negedge clk);
                reset_pin_n = 1'b1;
            end
        join
        check(32'(n_cmd - c + n_drop - d), 32'h0, "reset frame");
        run(4'h1, 3'h3, 1'b0, 1'b1);
    endtask
    task automatic t_protect();
        map_write_data = 8'h04;
        run(4'h8, 3'h0, 1'b0, 1'b0);
        write_protect_n = 1'b0;
        run(4'h1, 3'h2, 1'b1, 1'b1);
        run(4'h4, 3'h3, 1'b0, 1'b1);
        map_write_data = 8'h08;
        run(4'h8, 3'h0, 1'b1, 1'b0);
        check(32'(protected_sector_map), 32'h4, "map");
        write_protect_driven = 1'b0;
        run(4'h1, 3'h2, 1'b0, 1'b1);
        write_protect_driven = 1'b1;
        run(4'h6, 3'h0, 1'b0, 1'b0);
        run(4'h9, 3'h0, 1'b0, 1'b0);
        check({30'h0, permanent_lock, protection_enabled}, 32'h3, "enable lock");
    endtask
    task automatic print_verdict();
        $display("tests %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        t_por();
        repeat (8) @(negedge clk);
        t_erase();
        t_read();
        t_reset();
        t_protect();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule // tb_top
